//--- rtl/adccr_pkg.sv
package adccr_pkg;

  localparam int CLK_NS = 10;

  // Conversion modes
  typedef enum logic [1:0] {
    ADCCR_NORMAL,
    ADCCR_IMPULSE,
    ADCCR_WARP
  } adccr_mode_t;

  // Interface modes
  typedef enum logic [1:0] {
    ADCCR_PAR,
    ADCCR_MSTR_DURING,
    ADCCR_MSTR_AFTER,
    ADCCR_SLAVE
  } adccr_if_t;

  typedef struct packed {
    adccr_mode_t mode;
    adccr_if_t   ifmode;
    logic [1:0]  divider;
  } adccr_cfg_t;

  typedef struct packed {
    logic d;
    logic oe_n;
  } adccr_pin_t;

  localparam int RES_BITS = 14;

  // Conversion times (ns), maximum, so rounded down
  localparam int CONV_WARP_NS    = 850;
  localparam int CONV_NORMAL_NS  = 1100;
  localparam int CONV_IMPULSE_NS = 1350;
  localparam int CONV_WARP_CYC    = CONV_WARP_NS / CLK_NS;
  localparam int CONV_NORMAL_CYC  = CONV_NORMAL_NS / CLK_NS;
  localparam int CONV_IMPULSE_CYC = CONV_IMPULSE_NS / CLK_NS;

  // Least time from end of conversion to busy low, rounded up
  localparam int EOC_BUSY_NS  = 10;
  localparam int EOC_BUSY_CYC = (EOC_BUSY_NS + CLK_NS - 1) / CLK_NS;
  // Data valid before busy low, rounded up
  localparam int DATA_LEAD_NS  = 20;
  localparam int DATA_LEAD_CYC = (DATA_LEAD_NS + CLK_NS - 1) / CLK_NS;

  // Frame start, read during convert (typical)
  localparam int RDC_WARP_NS    = 50;
  localparam int RDC_NORMAL_NS  = 290;
  localparam int RDC_IMPULSE_NS = 530;
  // Frame start, read after convert (typical)
  localparam int RAC_WARP_NS    = 710;
  localparam int RAC_NORMAL_NS  = 950;
  localparam int RAC_IMPULSE_NS = 1190;

  // Frame end to busy low (typical)
  localparam int FRAME_BUSY_NS  = 25;
  localparam int FRAME_BUSY_CYC = (FRAME_BUSY_NS + CLK_NS - 1) / CLK_NS;

  // Serial clock least periods per divider code, rounded up
  localparam int SCLK_P0_NS = 30;
  localparam int SCLK_P1_NS = 60;
  localparam int SCLK_P2_NS = 120;
  localparam int SCLK_P3_NS = 240;
  localparam int SCLK_P0_CYC = (SCLK_P0_NS + CLK_NS - 1) / CLK_NS;
  localparam int SCLK_P1_CYC = (SCLK_P1_NS + CLK_NS - 1) / CLK_NS;
  localparam int SCLK_P2_CYC = (SCLK_P2_NS + CLK_NS - 1) / CLK_NS;
  localparam int SCLK_P3_CYC = (SCLK_P3_NS + CLK_NS - 1) / CLK_NS;

  // Longest busy rise delay and output release (max times, rounded down)
  localparam int BUSY_RISE_NS  = 35;
  localparam int BUSY_RISE_CYC = BUSY_RISE_NS / CLK_NS;
  localparam int RELEASE_NS    = 10;
  localparam int RELEASE_CYC   = RELEASE_NS / CLK_NS;
  // Slave data update window 2..18 ns: one cycle after sampled edge
  localparam int SLV_MAX_NS    = 18;
  localparam int SLV_CYC       = SLV_MAX_NS / CLK_NS;

  localparam logic [10:0] CNT_ONE  = 11'h001;
  localparam logic [10:0] CNT_ZERO = 11'h000;

endpackage : adccr_pkg

//--- rtl/adccr_core.sv
`timescale 1ns/1ns
`default_nettype none
module adccr_core (
  input  wire logic                 i_clk,
  input  wire logic                 i_rst_n,
  input  wire logic                 i_conversion_start_n,
  input  wire adccr_pkg::adccr_cfg_t i_cfg,
  input  wire logic                 i_cs_n,
  input  wire logic                 i_serial_data_clock,
  input  wire logic [13:0]          i_sample,
  output logic                      o_busy,
  output logic [13:0]               o_data,
  output adccr_pkg::adccr_pin_t     o_serial_data_output,
  output adccr_pkg::adccr_pin_t     o_frame,
  output adccr_pkg::adccr_pin_t     o_serial_clock_out
);

  typedef enum logic [2:0] {ST_IDLE, ST_CONV, ST_EOC, ST_SHIFT, ST_TAIL} adccr_st_t;

  adccr_st_t   st_q;
  logic [10:0] cnt_q;
  logic [10:0] conv_len, fr_start, sclk_half, cap_at;
  logic [13:0] res_q, shf_q;
  logic [4:0]  bit_q;
  logic [7:0]  div_q;
  logic        start_q, busy_q, frame_q, sclk_q, sdo_q, serial_data_clock_q;
  logic        start_fall, serial_data_clock_rise, div_tick, mstr, rac, frame_go;

  assign start_fall = start_q & ~i_conversion_start_n;
  assign serial_data_clock_rise = i_serial_data_clock & ~serial_data_clock_q;
  assign mstr       = (i_cfg.ifmode == adccr_pkg::ADCCR_MSTR_DURING) | rac;
  assign rac        = i_cfg.ifmode == adccr_pkg::ADCCR_MSTR_AFTER;

  assign conv_len = (i_cfg.mode == adccr_pkg::ADCCR_WARP) ? 11'(adccr_pkg::CONV_WARP_CYC) :
                    (i_cfg.mode == adccr_pkg::ADCCR_IMPULSE) ? 11'(adccr_pkg::CONV_IMPULSE_CYC)
                    : 11'(adccr_pkg::CONV_NORMAL_CYC);
  // Frame start offsets per mode
  assign fr_start = rac ?
    ((i_cfg.mode == adccr_pkg::ADCCR_WARP) ? 11'(adccr_pkg::RAC_WARP_NS / adccr_pkg::CLK_NS) :
     (i_cfg.mode == adccr_pkg::ADCCR_IMPULSE) ? 11'(adccr_pkg::RAC_IMPULSE_NS / adccr_pkg::CLK_NS)
     : 11'(adccr_pkg::RAC_NORMAL_NS / adccr_pkg::CLK_NS)) :
    ((i_cfg.mode == adccr_pkg::ADCCR_WARP) ? 11'(adccr_pkg::RDC_WARP_NS / adccr_pkg::CLK_NS) :
     (i_cfg.mode == adccr_pkg::ADCCR_IMPULSE) ? 11'(adccr_pkg::RDC_IMPULSE_NS / adccr_pkg::CLK_NS)
     : 11'(adccr_pkg::RDC_NORMAL_NS / adccr_pkg::CLK_NS));
  // Half period, rounded up so period never under the minimum
  assign sclk_half = (~rac || i_cfg.divider == 2'h0) ? 11'((adccr_pkg::SCLK_P0_CYC + 1) / 2) :
                     (i_cfg.divider == 2'h1) ? 11'(adccr_pkg::SCLK_P1_CYC / 2) :
                     (i_cfg.divider == 2'h2) ? 11'(adccr_pkg::SCLK_P2_CYC / 2)
                     : 11'(adccr_pkg::SCLK_P3_CYC / 2);
  assign div_tick = div_q == 8'(sclk_half - adccr_pkg::CNT_ONE);
  // Read-after frame opens before conversion end, so take the result first
  assign cap_at = rac ? fr_start - adccr_pkg::CNT_ONE
                      : conv_len - 11'(adccr_pkg::DATA_LEAD_CYC + 1);
  // Frame in read-during starts mid conversion; previous result is shifted
  assign frame_go = mstr && cnt_q == fr_start && !frame_q && st_q != ST_IDLE;

  // Start edge taken immediately; busy rises next edge, 10 ns < 35 ns
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q    <= ST_IDLE;
      cnt_q   <= adccr_pkg::CNT_ZERO;
      start_q <= 1'b1;
      busy_q  <= 1'b0;
      res_q   <= 14'h0000;
      o_data  <= 14'h0000;
    end else begin
      start_q <= i_conversion_start_n;
      cnt_q   <= (st_q == ST_IDLE) ? adccr_pkg::CNT_ZERO : cnt_q + adccr_pkg::CNT_ONE;
      unique case (st_q)
        ST_IDLE: if (start_fall) begin
          st_q   <= ST_CONV;
          busy_q <= 1'b1;
        end
        // Result captured DATA_LEAD_CYC before the busy fall, or one cycle before the frame opens in read-after mode
        ST_CONV: if (cnt_q == cap_at) begin
          res_q  <= i_sample;
          o_data <= i_sample;
          st_q   <= ST_EOC;
        end
        // Busy held past end of conversion
        ST_EOC: if (cnt_q == conv_len - adccr_pkg::CNT_ONE) begin
          st_q <= rac ? ST_SHIFT : ST_IDLE;
          busy_q <= rac;
        end
        ST_SHIFT: if (!frame_q && bit_q == 5'(adccr_pkg::RES_BITS)) begin
          st_q  <= ST_TAIL;
          cnt_q <= adccr_pkg::CNT_ZERO;
        end
        // Busy drops four cycles (40 ns) after frame end in read-after mode
        ST_TAIL: if (cnt_q == 11'(adccr_pkg::FRAME_BUSY_CYC - 1)) begin
          st_q   <= ST_IDLE;
          busy_q <= 1'b0;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // Master and slave serial shifter and clock divider
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      frame_q <= 1'b0;
      sclk_q  <= 1'b0;
      div_q   <= 8'h00;
      bit_q   <= 5'h00;
      shf_q   <= 14'h0000;
      sdo_q   <= 1'b0;
      serial_data_clock_q <= 1'b0;
    end else begin
      serial_data_clock_q <= i_serial_data_clock;
      if (frame_go) begin
        frame_q <= 1'b1;
        // Clock parks high after a frame; restart low or the MSB is lost
        sclk_q  <= 1'b0;
        shf_q   <= {res_q[12:0], 1'b0};
        sdo_q   <= res_q[13];
        bit_q   <= 5'h00;
        div_q   <= 8'h00;
      end else if (frame_q) begin
        div_q <= div_tick ? 8'h00 : div_q + 8'h01;
        if (div_tick) begin
          sclk_q <= ~sclk_q;
          if (sclk_q) begin
            sdo_q <= shf_q[13];
            shf_q <= {shf_q[12:0], 1'b0};
          end else begin
            bit_q <= bit_q + 5'h01;
            if (bit_q == 5'(adccr_pkg::RES_BITS - 1)) frame_q <= 1'b0;
          end
        end
      end else if (!mstr && start_fall) begin
        shf_q <= {res_q[12:0], 1'b0};
        sdo_q <= res_q[13];
      end else if (!mstr && serial_data_clock_rise) begin
        // Slave: update one cycle after sampled edge, within 18 ns
        sdo_q <= shf_q[13];
        shf_q <= {shf_q[12:0], 1'b0};
      end
    end
  end

  assign o_busy = busy_q;
  // Release combinational on chip select, 0 ns < 10 ns
  assign o_serial_data_output = '{d: sdo_q, oe_n: i_cs_n};
  assign o_frame              = '{d: frame_q, oe_n: i_cs_n | ~mstr};
  assign o_serial_clock_out   = '{d: sclk_q, oe_n: i_cs_n | ~mstr};

  property p_busy_rise;
    @(posedge i_clk) disable iff (!i_rst_n)
      (st_q == ST_IDLE && start_fall) |=> o_busy;
  endproperty
  a_busy_rise: assert property (p_busy_rise) else $error("busy late");

  property p_busy_max;
    @(posedge i_clk) disable iff (!i_rst_n)
      ($rose(o_busy) && !rac && i_cfg.mode == adccr_pkg::ADCCR_WARP)
        |-> ##[1:85] !o_busy;
  endproperty
  a_busy_max: assert property (p_busy_max) else $error("busy too long");

  property p_data_lead;
    @(posedge i_clk) disable iff (!i_rst_n)
      $changed(o_data) |-> o_busy [*2];
  endproperty
  a_data_lead: assert property (p_data_lead) else $error("data late");

  property p_eoc_gap;
    @(posedge i_clk) disable iff (!i_rst_n)
      (st_q == ST_CONV ##1 st_q == ST_EOC) |-> o_busy;
  endproperty
  a_eoc_gap: assert property (p_eoc_gap) else $error("busy early");

  property p_rac_busy;
    @(posedge i_clk) disable iff (!i_rst_n)
      (rac && $fell(frame_q)) |-> o_busy ##1 o_busy ##[1:3] !o_busy;
  endproperty
  a_rac_busy: assert property (p_rac_busy) else $error("busy tail");

  property p_release;
    @(posedge i_clk) disable iff (!i_rst_n)
      i_cs_n |-> (o_serial_data_output.oe_n && o_frame.oe_n && o_serial_clock_out.oe_n);
  endproperty
  a_release: assert property (p_release) else $error("not released");

  property p_sclk_min;
    @(posedge i_clk) disable iff (!i_rst_n)
      $rose(sclk_q) |=> sclk_q;
  endproperty
  a_sclk_min: assert property (p_sclk_min) else $error("clock short");

  property p_frame_rdc;
    @(posedge i_clk) disable iff (!i_rst_n)
      (st_q == ST_IDLE && start_fall && i_cfg.ifmode == adccr_pkg::ADCCR_MSTR_DURING
       && i_cfg.mode == adccr_pkg::ADCCR_WARP) |-> ##7 frame_q;
  endproperty
  a_frame_rdc: assert property (p_frame_rdc) else $error("frame timing");

  property p_busy_nrm;
    @(posedge i_clk) disable iff (!i_rst_n)
      ($rose(o_busy) && !rac && i_cfg.mode == adccr_pkg::ADCCR_NORMAL)
        |-> ##[1:110] !o_busy;
  endproperty
  a_busy_nrm: assert property (p_busy_nrm) else $error("busy too long");

  property p_busy_imp;
    @(posedge i_clk) disable iff (!i_rst_n)
      ($rose(o_busy) && !rac && i_cfg.mode == adccr_pkg::ADCCR_IMPULSE)
        |-> ##[1:135] !o_busy;
  endproperty
  a_busy_imp: assert property (p_busy_imp) else $error("busy too long");

  property p_sclk_low;
    @(posedge i_clk) disable iff (!i_rst_n)
      (frame_q && $fell(sclk_q)) |=> !sclk_q;
  endproperty
  a_sclk_low: assert property (p_sclk_low) else $error("clock low short");

endmodule : adccr_core
`default_nettype wire

//--- verif/adccr_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module adccr_host_model (
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_n,
  input  wire logic                  i_clr,
  input  wire logic                  i_slave_en,
  input  wire adccr_pkg::adccr_pin_t i_sdo,
  input  wire adccr_pkg::adccr_pin_t i_sclk,
  output logic                       o_sclk,
  output logic [13:0]                o_word,
  output logic [4:0]                 o_bits
);
  logic [2:0] ph_q;
  logic       mclk_q;
  wire        more = o_bits < 5'h0e;
  wire        m_rise = i_sclk.d & ~mclk_q & ~i_sclk.oe_n & more;
  wire        s_rise = i_slave_en & more & (ph_q == 3'h3);
  // Released line reads as the inverse so a sample taken then shows up
  wire        sdo_seen = i_sdo.oe_n ? ~i_sdo.d : i_sdo.d;
  // Slave clock parked low outside frames; 80 ns period
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ph_q   <= 3'h0;
      mclk_q <= 1'b0;
      o_sclk <= 1'b0;
      o_word <= 14'h0000;
      o_bits <= 5'h00;
    end else begin
      mclk_q <= i_sclk.d;
      ph_q   <= (i_slave_en && more) ? ph_q + 3'h1 : 3'h0;
      o_sclk <= i_slave_en && more && ph_q >= 3'h3 && ph_q <= 3'h6;
      if (i_clr) begin
        o_word <= 14'h0000;
        o_bits <= 5'h00;
      end else if (s_rise || m_rise) begin
        // Slave bit taken just before our own rise moves it
        o_word <= {o_word[12:0], sdo_seen};
        o_bits <= o_bits + 5'h01;
      end
    end
  end
endmodule : adccr_host_model
`default_nettype wire

//--- verif/adccr_core_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module adccr_core_tb_top;
  logic                  i_clk, i_rst_n, start_n, cs_n, slave_en, clr, slv_clk, busy;
  logic [13:0]           sample, data, word;
  logic [4:0]            bits;
  adccr_pkg::adccr_cfg_t cfg;
  adccr_pkg::adccr_pin_t sdo, frame, sclk;
  int                    bad_count, checks_done, rise, len, lead, fr, fe;

  adccr_core adccr_core_inst (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_conversion_start_n(start_n), .i_cfg(cfg),
    .i_cs_n(cs_n), .i_serial_data_clock(slv_clk), .i_sample(sample), .o_busy(busy),
    .o_data(data), .o_serial_data_output(sdo), .o_frame(frame), .o_serial_clock_out(sclk));
  adccr_host_model adccr_host_model_inst (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_clr(clr), .i_slave_en(slave_en), .i_sdo(sdo),
    .i_sclk(sclk), .o_sclk(slv_clk), .o_word(word), .o_bits(bits));

  always #5 i_clk = ~i_clk;

  task automatic final_report;
    if (bad_count == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report

  task automatic chk_val(input logic [13:0] got, input logic [13:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_rng(input int got, input int lo, input int hi);
    checks_done++;
    if (got < lo || got > hi) begin
      bad_count++;
      $display("[FAIL] %0t count %0d not in %0d..%0d", $time, got, lo, hi);
    end
  endtask : chk_rng

  task automatic run_conv(input adccr_pkg::adccr_cfg_t c, input logic [13:0] s, input bit again);
    logic [13:0] prev;
    int          n;
    @(posedge i_clk);
    cfg <= c;
    sample <= s;
    clr <= 1'b1;
    repeat (2) @(posedge i_clk);
    clr <= 1'b0;
    start_n <= 1'b0;
    prev = data;
    rise = 0;
    len = 0;
    lead = 0;
    fr = 0;
    fe = 0;
    for (n = 1; n <= 3000; n++) begin
      @(posedge i_clk);
      // Second start lands mid-conversion and must be ignored
      start_n <= !(again && n == 30);
      if (busy === 1'b1 && rise == 0) rise = n;
      if (busy === 1'b1) len++;
      lead = (data === prev) ? lead + 1 : 0;
      prev = data;
      if (frame.d === 1'b1 && fr == 0) fr = n;
      if (frame.d !== 1'b1 && fr > 0 && fe == 0) fe = n;
      if (rise > 0 && busy !== 1'b1) break;
    end
    if (n > 3000) begin
      bad_count++;
      final_report();
    end
    repeat (60) @(posedge i_clk);
  endtask : run_conv

  task automatic t_parallel;
    int m;
    for (int i = 0; i < 3; i++) begin
      m = (i == 2) ? adccr_pkg::CONV_WARP_CYC : (i == 1) ? adccr_pkg::CONV_IMPULSE_CYC
                                               : adccr_pkg::CONV_NORMAL_CYC;
      run_conv({2'(i), adccr_pkg::ADCCR_PAR, 2'h0}, 14'h2a50 + 14'(i), 1'b1);
      chk_rng(rise, 1, 3);
      chk_rng(len, m - 4, m);
      chk_rng(rise + len - lead, 1, m + 1);
      chk_rng(lead, adccr_pkg::DATA_LEAD_CYC, 200);
      chk_val(data, 14'h2a50 + 14'(i));
    end
  endtask : t_parallel

  task automatic t_rac;
    int h[4] = '{2, 3, 6, 12};
    int tmax[4] = '{160, 235, 375, 675};
    for (int d = 0; d < 4; d++) begin
      run_conv({adccr_pkg::ADCCR_WARP, adccr_pkg::ADCCR_MSTR_AFTER, 2'(d)}, 14'h1c30 + 14'(d), 1'b0);
      chk_rng(fr, 70, 74);
      chk_rng(len, 28 * h[d], tmax[d]);
      chk_rng(rise + len - fe, 1, 4);
      chk_val(word, 14'h1c30 + 14'(d));
    end
  endtask : t_rac

  task automatic t_rdc;
    run_conv({adccr_pkg::ADCCR_NORMAL, adccr_pkg::ADCCR_MSTR_DURING, 2'h0}, 14'h0f0f, 1'b0);
    chk_rng(fr, 28, 32);
    chk_val(word, 14'h1c33);
    run_conv({adccr_pkg::ADCCR_WARP, adccr_pkg::ADCCR_MSTR_DURING, 2'h0}, 14'h0550, 1'b0);
    chk_rng(fr, 4, 8);
    chk_val(word, 14'h0f0f);
  endtask : t_rdc

  task automatic t_release;
    chk_val({11'h000, sdo.oe_n, frame.oe_n, sclk.oe_n}, 14'h0000);
    cs_n <= 1'b1;
    @(posedge i_clk);
    chk_val({11'h000, sdo.oe_n, frame.oe_n, sclk.oe_n}, 14'h0007);
    cs_n <= 1'b0;
  endtask : t_release

  task automatic t_slave;
    int n;
    run_conv({adccr_pkg::ADCCR_WARP, adccr_pkg::ADCCR_SLAVE, 2'h0}, 14'h3a96, 1'b0);
    // Shifter loads at the start edge, so this read returns the run before
    run_conv({adccr_pkg::ADCCR_WARP, adccr_pkg::ADCCR_SLAVE, 2'h0}, 14'h05a9, 1'b0);
    slave_en <= 1'b1;
    for (n = 0; n < 300 && bits !== 5'h0e; n++) @(posedge i_clk);
    slave_en <= 1'b0;
    if (n >= 300) begin
      bad_count++;
      final_report();
    end
    chk_val(word, 14'h3a96);
  endtask : t_slave

  initial begin
    i_clk = 1'b0;
    i_rst_n = 1'b0;
    start_n = 1'b1;
    cs_n = 1'b0;
    slave_en = 1'b0;
    clr = 1'b0;
    sample = 14'h0000;
    cfg = '0;
    bad_count = 0;
    checks_done = 0;
    repeat (20) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (2) @(posedge i_clk);
    t_parallel();
    t_rac();
    t_rdc();
    t_release();
    t_slave();
    final_report();
  end
endmodule : adccr_core_tb_top
`default_nettype wire
